//--- design/issp_core.sv
// I2C slave serial port: link shifter on the bus clock, byte engine on mclk.
// Assumes open-drain pads resolved outside and a master that keeps I2C timing.
`include "issp_regs.svh"
module issp_core (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Bus pins; the clock pin also clocks the link shifter
  input  wire logic       scl_clk,
  output logic            scl_o,
  output logic            scl_oe_n,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n,
  // Control
  input  wire logic [7:0] ctrl_in,
  input  wire logic [4:3] port_c_direction_bits,
  input  wire logic [7:0] slave_address_reg,
  input  wire logic       ovf_clr,
  input  wire logic       done_clr,
  // Status
  output logic      [7:0] serial_control_rd,
  output logic      [7:0] serial_status_reg,
  output logic            transfer_done_flag,
  output logic            receive_overflow_bit,
  // Receive buffer
  output logic      [7:0] serial_buffer_reg,
  input  wire logic       buf_rd,
  // Transmit data
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);

  issp_pkg::issp_state_e st_q;
  issp_pkg::issp_state_e nxt_q;
  issp_pkg::issp_byte_t  serial_shift_reg;
  issp_pkg::issp_byte_t  lk_byte_q;
  issp_pkg::issp_byte_t  hi_q;
  issp_pkg::issp_byte_t  tx_sh_q;
  issp_pkg::issp_byte_t  tx_next;
  issp_pkg::issp_byte_t  rx_byte;
  logic [3:0]            lk_cnt_q;
  logic [2:0]            tx_cnt_q;
  logic [2:0]            sync_q;
  logic [2:0]            prev_q;
  logic [3:0]            mode;
  logic                  lk_tgl_q;
  logic                  link_rst;
  logic                  frame_rst_q;
  logic                  hi_ok_q;
  logic                  sda_drv_q;
  logic                  bf_q;
  logic                  da_q;
  logic                  ua_q;
  logic                  rw_q;
  logic                  start_q;
  logic                  stop_q;
  logic                  i2c_on;
  logic                  slave_on;
  logic                  ten;
  logic                  irq_mode;
  logic                  scl_s;
  logic                  sda_s;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  byte_evt;
  logic                  start_det;
  logic                  stop_det;
  logic                  run;
  logic                  gcall;
  logic                  hdr_byte;
  logic                  m7;
  logic                  m10hi;
  logic                  m10rd;
  logic                  m10lo;
  logic                  hit_addr;
  logic                  hit;
  logic                  take;
  logic                  take_addr;
  logic                  take_data;
  logic                  ovf_set;
  logic                  tx_done;
  logic                  tx_load;
  logic                  done_set;

  issp_stream_if #(.W(8)) tx_in ();
  issp_stream_if #(.W(8)) tx_out ();

  // Mode code known to the port
  function automatic logic mode_valid(input logic [3:0] m);
    return (m == `ISSP_MODE_S7) || (m == `ISSP_MODE_S10) || (m == `ISSP_MODE_S7I) ||
           (m == `ISSP_MODE_S10I) || (m == `ISSP_MODE_FWM);
  endfunction

  // Mode and pin decode
  assign mode     = ctrl_in[`ISSP_MODE_MSB:`ISSP_MODE_LSB];
  assign i2c_on   = ctrl_in[`ISSP_EN_BIT] & mode_valid(mode) &
                    port_c_direction_bits[`ISSP_DIR_SCL] &
                    port_c_direction_bits[`ISSP_DIR_SDA];
  assign slave_on = i2c_on & (mode != `ISSP_MODE_FWM);
  assign ten      = (mode == `ISSP_MODE_S10) || (mode == `ISSP_MODE_S10I);
  assign irq_mode = (mode == `ISSP_MODE_S7I) || (mode == `ISSP_MODE_S10I) ||
                    (mode == `ISSP_MODE_FWM);

  // Open-drain pins: only ever pull low, never stretch the clock
  assign scl_o    = 1'b0;
  assign scl_oe_n = 1'b1;
  assign sda_o    = 1'b0;
  assign sda_oe_n = ~(i2c_on & sda_drv_q);

  // Link domain is reset by each start or stop, so a frame always
  // begins at bit zero even though the bus clock may stand still
  assign link_rst = sys_rst | frame_rst_q;
  // Link shifter; data is stable around each rising bus clock
  always_ff @(posedge scl_clk or posedge link_rst)
  begin
    if (link_rst)
    begin
      serial_shift_reg <= 8'h00;
      lk_cnt_q         <= 4'h0;
    end
    else
    begin
      serial_shift_reg <= {serial_shift_reg[6:0], sda_i};
      lk_cnt_q         <= (lk_cnt_q == 4'h8) ? 4'h0 : lk_cnt_q + 4'h1;
    end
  end

  // Byte handoff: word held for nine bus clocks while its toggle crosses
  always_ff @(posedge scl_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lk_byte_q <= 8'h00;
      lk_tgl_q  <= 1'b0;
    end
    else if (!frame_rst_q && lk_cnt_q == 4'h7)
    begin
      lk_byte_q <= {serial_shift_reg[6:0], sda_i};
      lk_tgl_q  <= ~lk_tgl_q;
    end
  end

  // Pins and handoff toggle into mclk
  issp_sync #(.W(3)) u_sync (
    .clk (mclk),
    .rst (sys_rst),
    .d   ({scl_clk, sda_i, lk_tgl_q}),
    .q   (sync_q)
  );

  // Edge history behind the synchroniser
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      prev_q <= 3'h6;
    else
      prev_q <= sync_q;
  end

  // Bus events seen from mclk
  assign scl_s     = sync_q[2];
  assign sda_s     = sync_q[1];
  assign scl_rise  = scl_s & ~prev_q[2];
  assign scl_fall  = ~scl_s & prev_q[2];
  assign byte_evt  = sync_q[0] ^ prev_q[0];
  assign start_det = i2c_on & scl_s & prev_q[2] & prev_q[1] & ~sda_s;
  assign stop_det  = i2c_on & scl_s & prev_q[2] & ~prev_q[1] & sda_s;
  assign run       = slave_on & ~start_det & ~stop_det;

  // Address compare on the handed-over byte
  assign rx_byte   = lk_byte_q;
  assign gcall     = (rx_byte[7:1] == `ISSP_GCALL_ADDR);
  assign hdr_byte  = (rx_byte[7:3] == `ISSP_TENBIT_HDR);
  assign m7        = ~ten & ~gcall & (rx_byte[7:1] == slave_address_reg[7:1]);
  assign m10hi     = ten & hdr_byte & ~rx_byte[0] &
                     (rx_byte[7:1] == slave_address_reg[7:1]);
  assign m10rd     = ten & hi_ok_q & hdr_byte & rx_byte[0] & (rx_byte[7:1] == hi_q[7:1]);
  assign m10lo     = (rx_byte == slave_address_reg);
  assign hit_addr  = (st_q == issp_pkg::ST_ADDR) & (m7 | m10hi | m10rd);
  assign hit       = byte_evt & run & (hit_addr | ((st_q == issp_pkg::ST_ADDR2) & m10lo) |
                     (st_q == issp_pkg::ST_RX));
  assign take      = hit & ~bf_q;
  assign take_addr = take & (st_q != issp_pkg::ST_RX);
  assign take_data = take & (st_q == issp_pkg::ST_RX);
  assign ovf_set   = hit & bf_q;
  assign tx_done   = run & scl_fall & (st_q == issp_pkg::ST_TX) & (tx_cnt_q == 3'h7);
  assign done_set  = take | tx_done | (irq_mode & (start_det | stop_det));

  // Transmit FIFO: drained only as the master clocks bytes out
  assign tx_in.valid  = tx_valid;
  assign tx_in.data   = tx_data;
  assign tx_ready     = tx_in.ready;
  assign tx_load      = run & scl_fall & (((st_q == issp_pkg::ST_ACKD) &
                        (nxt_q == issp_pkg::ST_TX)) | (st_q == issp_pkg::ST_TXW));
  assign tx_out.ready = tx_load;
  // An empty FIFO sends all ones, which leaves the line released
  assign tx_next      = tx_out.valid ? tx_out.data : `ISSP_TX_IDLE;

  issp_fifo #(.W(8), .D(`ISSP_FIFO_DEPTH)) u_txfifo (
    .clk (mclk),
    .rst (sys_rst),
    .wr  (tx_in),
    .rd  (tx_out)
  );

  // Frame reset: raised by start or stop, dropped once the clock is low
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      frame_rst_q <= 1'b1;
    else if (!i2c_on || start_det || stop_det)
      frame_rst_q <= 1'b1;
    else if (!scl_s)
      frame_rst_q <= 1'b0;
  end

  // Byte engine
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q      <= issp_pkg::ST_IDLE;
      nxt_q     <= issp_pkg::ST_IDLE;
      sda_drv_q <= 1'b0;
      tx_sh_q   <= 8'hff;
      tx_cnt_q  <= 3'h0;
      hi_q      <= 8'h00;
      hi_ok_q   <= 1'b0;
    end
    else if (!slave_on || stop_det)
    begin
      st_q      <= issp_pkg::ST_IDLE;
      sda_drv_q <= 1'b0;
      hi_ok_q   <= 1'b0;
    end
    else if (start_det)
    begin
      st_q      <= issp_pkg::ST_ADDR;
      sda_drv_q <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        issp_pkg::ST_IDLE, issp_pkg::ST_IGNORE:
          st_q <= st_q;
        issp_pkg::ST_ADDR:
          if (byte_evt)
          begin
            // A miss or a full buffer leaves the bus unacknowledged
            st_q <= take ? issp_pkg::ST_ACKW : issp_pkg::ST_IGNORE;
            if (m10hi)
            begin
              nxt_q   <= issp_pkg::ST_ADDR2;
              hi_q    <= rx_byte;
              hi_ok_q <= take;
            end
            else
              nxt_q <= rx_byte[0] ? issp_pkg::ST_TX : issp_pkg::ST_RX;
          end
        issp_pkg::ST_ADDR2:
          if (byte_evt)
          begin
            st_q  <= take ? issp_pkg::ST_ACKW : issp_pkg::ST_IGNORE;
            nxt_q <= issp_pkg::ST_RX;
          end
        issp_pkg::ST_RX:
          if (byte_evt)
            st_q <= take ? issp_pkg::ST_ACKW : issp_pkg::ST_IGNORE;
        issp_pkg::ST_ACKW:
          if (scl_fall)
          begin
            sda_drv_q <= 1'b1;
            st_q      <= issp_pkg::ST_ACKD;
          end
        issp_pkg::ST_ACKD, issp_pkg::ST_TXW:
          if (scl_fall)
          begin
            if (tx_load)
            begin
              sda_drv_q <= ~tx_next[7];
              tx_sh_q   <= {tx_next[6:0], 1'b1};
              tx_cnt_q  <= 3'h0;
              st_q      <= issp_pkg::ST_TX;
            end
            else
            begin
              sda_drv_q <= 1'b0;
              st_q      <= nxt_q;
            end
          end
        issp_pkg::ST_TX:
          if (scl_fall)
          begin
            if (tx_cnt_q == 3'h7)
            begin
              sda_drv_q <= 1'b0;
              st_q      <= issp_pkg::ST_MACK;
            end
            else
            begin
              sda_drv_q <= ~tx_sh_q[7];
              tx_sh_q   <= {tx_sh_q[6:0], 1'b1};
              tx_cnt_q  <= tx_cnt_q + 3'h1;
            end
          end
        issp_pkg::ST_MACK:
          if (scl_rise)
            st_q <= sda_s ? issp_pkg::ST_IGNORE : issp_pkg::ST_TXW;
        default:
          st_q <= issp_pkg::ST_IDLE;
      endcase
    end
  end

  // Buffer, flags and status; a set beats a same-cycle clear
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      serial_buffer_reg    <= 8'h00;
      bf_q                 <= 1'b0;
      transfer_done_flag   <= 1'b0;
      receive_overflow_bit <= 1'b0;
      da_q                 <= 1'b0;
      ua_q                 <= 1'b0;
      rw_q                 <= 1'b0;
      start_q              <= 1'b0;
      stop_q               <= 1'b0;
    end
    else
    begin
      if (take)
        serial_buffer_reg <= rx_byte;
      bf_q                 <= take | (bf_q & ~buf_rd);
      transfer_done_flag   <= done_set | (transfer_done_flag & ~done_clr);
      receive_overflow_bit <= ovf_set | (receive_overflow_bit & ~ovf_clr);
      if (take)
        da_q <= take_data;
      if (take_addr && (st_q == issp_pkg::ST_ADDR))
      begin
        rw_q <= rx_byte[0];
        ua_q <= m10hi;
      end
      else if (take_addr)
        ua_q <= 1'b0;
      if (start_det || stop_det)
      begin
        start_q <= start_det;
        stop_q  <= stop_det;
      end
    end
  end

  // Read-only views; nothing here can be written
  always_comb
  begin
    serial_status_reg                 = 8'h00;
    serial_status_reg[`ISSP_ST_BF]    = bf_q;
    serial_status_reg[`ISSP_ST_UA]    = ua_q;
    serial_status_reg[`ISSP_ST_RW]    = rw_q;
    serial_status_reg[`ISSP_ST_START] = start_q;
    serial_status_reg[`ISSP_ST_STOP]  = stop_q;
    serial_status_reg[`ISSP_ST_DA]    = da_q;
    serial_control_rd                 = ctrl_in;
    serial_control_rd[`ISSP_OV_BIT]   = receive_overflow_bit;
    serial_control_rd[7]              = 1'b0;
  end

endmodule

//--- design/issp_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes D is a power of two and one clock for both sides.
module issp_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // Fill and drain sides
  issp_stream_if.snk wr,
  issp_stream_if.src rd
);

  localparam int AW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;
  logic         full;
  logic         empty;
  logic         push;
  logic         pop;

  // Extra pointer bit tells full from empty
  assign full     = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign empty    = (wp_q == rp_q);
  assign wr.ready = ~full;
  assign rd.valid = ~empty;
  assign rd.data  = mem_q[rp_q[AW-1:0]];
  assign push     = wr.valid & ~full;
  assign pop      = rd.ready & ~empty;

  // Storage, no reset needed
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wp_q[AW-1:0]] <= wr.data;
  end

  // Pointers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
    end
  end

endmodule

//--- design/issp_pkg.sv
// Types shared by the I2C slave serial port modules.
// Assumes nothing of its surroundings.
package issp_pkg;

  // Byte engine states, one-hot
  typedef enum logic [9:0] {
    ST_IDLE   = 10'h001,
    ST_ADDR   = 10'h002,
    ST_ADDR2  = 10'h004,
    ST_RX     = 10'h008,
    ST_ACKW   = 10'h010,
    ST_ACKD   = 10'h020,
    ST_TX     = 10'h040,
    ST_MACK   = 10'h080,
    ST_TXW    = 10'h100,
    ST_IGNORE = 10'h200
  } issp_state_e;

  typedef logic [7:0] issp_byte_t;

endpackage

//--- design/issp_regs.svh
// Bit positions, mode codes and fixed values of the I2C slave serial port.
// Assumes inclusion by bare name; definitions only.
`ifndef ISSP_REGS_SVH
`define ISSP_REGS_SVH

// Control word fields
`define ISSP_EN_BIT      5
`define ISSP_OV_BIT      6
`define ISSP_MODE_MSB    3
`define ISSP_MODE_LSB    0

// Mode codes of the control word
`define ISSP_MODE_S7     4'h1
`define ISSP_MODE_S10    4'h2
`define ISSP_MODE_S7I    4'h3
`define ISSP_MODE_S10I   4'h4
`define ISSP_MODE_FWM    4'h5

// Direction bits of the clock and data pins
`define ISSP_DIR_SCL     3
`define ISSP_DIR_SDA     4

// Status word fields
`define ISSP_ST_BF       0
`define ISSP_ST_UA       1
`define ISSP_ST_RW       2
`define ISSP_ST_START    3
`define ISSP_ST_STOP     4
`define ISSP_ST_DA       5

// Address constants
`define ISSP_TENBIT_HDR  5'h1e
`define ISSP_GCALL_ADDR  7'h00

// Transmit path
`define ISSP_FIFO_DEPTH  16
`define ISSP_TX_IDLE     8'hff

`endif

//--- design/issp_stream_if.sv
// Valid/ready word stream between the port's own modules.
// Assumes both ends sit on one clock.
interface issp_stream_if #(
  parameter int W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- design/issp_sync.sv
// Two-flop level synchroniser, one lane per bit.
// Assumes inputs are levels that stay put for several clocks.
module issp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Lanes
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

//--- tb/issp_core_tb_top.sv
// Self-checking bench for the I2C slave serial port core.
// Assumes the behavioural master model and the bound checker.
`include "issp_regs.svh"
module issp_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk, sys_rst, scl, sda_out, sda_line, scl_line;
  logic       scl_o, scl_oe_n, sda_o, sda_oe_n, ovf_clr, done_clr, buf_rd;
  logic       transfer_done_flag, receive_overflow_bit, tx_valid, tx_ready, ack;
  logic [7:0] ctrl_in, slave_address_reg, serial_control_rd, serial_status_reg;
  logic [7:0] serial_buffer_reg, tx_data, rd;
  logic [4:3] port_c_direction_bits;
  int         mismatches, total_checks;
  int         cyc = 0;
  // {control, direction, 4'h0, done on start, acknowledge}
  logic [15:0] mt [5] = '{16'h21c1, 16'h23c3, 16'h01c0, 16'h2140, 16'h25c2};

  // Wired-AND lines with pull-ups
  assign sda_line = sda_out & (sda_oe_n | sda_o);
  assign scl_line = scl & (scl_oe_n | scl_o);

  issp_core u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .scl_clk(scl_line), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .ctrl_in(ctrl_in), .port_c_direction_bits(port_c_direction_bits),
    .slave_address_reg(slave_address_reg), .ovf_clr(ovf_clr), .done_clr(done_clr),
    .serial_control_rd(serial_control_rd), .serial_status_reg(serial_status_reg),
    .transfer_done_flag(transfer_done_flag), .receive_overflow_bit(receive_overflow_bit),
    .serial_buffer_reg(serial_buffer_reg), .buf_rd(buf_rd), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready)
  );
  issp_i2c_master u_mst (.scl(scl), .sda_out(sda_out), .sda_line(sda_line));

  // Core clock, 50 ns
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits end on a falling edge so outputs are settled
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic cfg(input logic [7:0] c, input logic [4:3] d, input logic [7:0] a);
    @(posedge mclk);
    #2;
    ctrl_in = c;
    port_c_direction_bits = d;
    slave_address_reg = a;
    tick(3);
  endtask

  // One-cycle software strobes {ovf_clr, done_clr, buf_rd}
  task automatic pulse(input logic [2:0] p);
    @(posedge mclk);
    #2;
    {ovf_clr, done_clr, buf_rd} = p;
    @(posedge mclk);
    #2;
    {ovf_clr, done_clr, buf_rd} = 3'h0;
    tick(1);
  endtask

  // Bus steps, then room for the 2-flop synchroniser
  task automatic wb(input logic [7:0] d);
    u_mst.wr_byte(d, ack);
    tick(6);
  endtask

  task automatic bus_start();
    u_mst.start();
    tick(6);
  endtask

  task automatic bus_stop();
    u_mst.stop();
    tick(6);
  endtask

  initial
  begin
    sys_rst = 1'b1;
    {ovf_clr, done_clr, buf_rd, tx_valid} = 4'h0;
    {ctrl_in, slave_address_reg, tx_data} = 24'h0;
    port_c_direction_bits = 2'b00;
    mismatches = 0;
    total_checks = 0;
    repeat (5) @(posedge mclk);
    #2 sys_rst = 1'b0;
    tick(1);
    chk(serial_status_reg, 8'h00);
    chk(serial_buffer_reg, 8'h00);
    chk({3'h0, scl_oe_n, sda_oe_n, tx_ready, transfer_done_flag, receive_overflow_bit}, 8'h1c);
    // Modes, enable and pin directions
    for (int i = 0; i < 5; i++)
    begin
      cfg(mt[i][15:8], mt[i][7:6], 8'h54);
      pulse(3'h7);
      bus_start();
      chk(8'(transfer_done_flag), 8'(mt[i][1]));
      wb(8'h54);
      chk(8'(ack), 8'(mt[i][0]));
      bus_stop();
    end
    // 7-bit write, double buffering, then overflow
    cfg(8'h21, 2'b11, 8'h54);
    pulse(3'h7);
    bus_start();
    chk(serial_status_reg & 8'h18, 8'h08);
    wb(8'h54);
    chk(serial_buffer_reg, 8'h54);
    chk(serial_status_reg & 8'h25, 8'h01);
    chk(8'(transfer_done_flag), 8'h01);
    pulse(3'h3);
    wb(8'h55);
    chk(serial_buffer_reg, 8'h55);
    chk(serial_status_reg & 8'h25, 8'h21);
    fork
      wb(8'h77);
      begin
        tick(40);
        pulse(3'h1);
      end
    join
    chk({ack, serial_buffer_reg[6:0]}, 8'hf7);
    wb(8'h66);
    chk({ack, serial_control_rd[6], receive_overflow_bit, serial_buffer_reg[4:0]}, 8'h77);
    bus_stop();
    chk(serial_status_reg & 8'h18, 8'h10);
    pulse(3'h4);
    chk(8'(receive_overflow_bit), 8'h00);
    // Address miss, then general call
    for (int j = 0; j < 2; j++)
    begin
      cfg(8'h21, 2'b11, j ? 8'h00 : 8'h54);
      pulse(3'h7);
      bus_start();
      wb(j ? 8'h00 : 8'h56);
      bus_stop();
      chk({6'h0, ack, transfer_done_flag}, 8'h00);
    end
    // Transmit FIFO filled to refusal, then read out whole
    cfg(8'h21, 2'b11, 8'h54);
    @(posedge mclk);
    #2 tx_valid = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      tx_data = 8'(i * 17 + 3);
      @(posedge mclk);
      #2;
    end
    tx_valid = 1'b0;
    tick(1);
    chk(8'(tx_ready), 8'h00);
    pulse(3'h7);
    bus_start();
    wb(8'h55);
    chk({ack, 4'h0, serial_status_reg[2:0]}, 8'h85);
    for (int i = 0; i < 16; i++)
    begin
      u_mst.rd_byte(i < 15, rd);
      tick(6);
      chk(rd, 8'(i * 17 + 3));
    end
    bus_stop();
    chk(8'(tx_ready), 8'h01);
    // 10-bit address, both 10-bit modes
    for (int m = 0; m < 2; m++)
    begin
      cfg(m ? 8'h24 : 8'h22, 2'b11, 8'hf2);
      pulse(3'h7);
      bus_start();
      wb(8'hf2);
      chk({6'h0, ack, serial_status_reg[`ISSP_ST_UA]}, 8'h03);
      cfg(m ? 8'h24 : 8'h22, 2'b11, 8'h34);
      pulse(3'h3);
      wb(8'h34);
      chk({ack, serial_buffer_reg[6:0]}, 8'hb4);
      // Repeated start with the stored header, read direction
      pulse(3'h1);
      bus_start();
      wb(8'hf3);
      chk({5'h0, ack, serial_status_reg[2:1]}, 8'h06);
      bus_stop();
    end
    end_of_test();
  end
endmodule

//--- tb/issp_i2c_master.sv
// Behavioural I2C bus master for the slave serial port bench.
// Assumes the bench resolves both lines with pull-ups.
module issp_i2c_master (
  // Lines
  output logic      scl,
  output logic      sda_out,
  input  wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // Ticks per clock phase; long enough for the slave's synchroniser
  localparam int HALF = 25;
  logic tck;

  // Link tick of 12 ns, unrelated to mclk; lines idle high
  initial
  begin
    tck = 1'b0;
    scl = 1'b1;
    sda_out = 1'b1;
    forever #6 tck = ~tck;
  end

  task automatic wait_t(input int n);
    repeat (n) @(posedge tck);
  endtask

  // Start or repeated start: data falls while clock high
  task automatic start();
    sda_out = 1'b1;
    wait_t(HALF);
    scl = 1'b1;
    wait_t(HALF);
    sda_out = 1'b0;
    wait_t(HALF);
    scl = 1'b0;
  endtask

  task automatic stop();
    wait_t(HALF / 4);
    sda_out = 1'b0;
    wait_t(HALF);
    scl = 1'b1;
    wait_t(HALF);
    sda_out = 1'b1;
    wait_t(HALF);
  endtask

  // Data set in the low phase, sampled just before the fall
  task automatic bit_x(input logic b, output logic r);
    wait_t(HALF / 4);
    sda_out = b;
    wait_t(HALF - HALF / 4);
    scl = 1'b1;
    wait_t(HALF);
    r = sda_line;
    scl = 1'b0;
  endtask

  // MSB first, ninth bit is the acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(~mack, r);
  endtask
endmodule

//--- tb/issp_sva.sv
// Concurrent checks on the ports of the I2C slave serial port core.
// Assumes the bind below; one clock domain, mclk, with sys_rst active high.
`include "issp_regs.svh"
module issp_sva (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       sys_rst,
  // Pins
  input wire logic       scl_o,
  input wire logic       sda_o,
  input wire logic       sda_oe_n,
  // Control
  input wire logic [7:0] ctrl_in,
  input wire logic [4:3] port_c_direction_bits,
  input wire logic       ovf_clr,
  input wire logic       done_clr,
  // Status
  input wire logic [7:0] serial_control_rd,
  input wire logic [7:0] serial_status_reg,
  input wire logic       transfer_done_flag,
  input wire logic       receive_overflow_bit,
  input wire logic [7:0] serial_buffer_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Pin drive only when the port is live
  off_quiet_a: assert property (!ctrl_in[`ISSP_EN_BIT] |-> sda_oe_n)
    else $error("data line driven while disabled");
  dir_quiet_a: assert property ((port_c_direction_bits != 2'b11)[*2] |-> sda_oe_n)
    else $error("data line driven with pins not inputs");
  master_idle_a: assert property ((ctrl_in[3:0] == `ISSP_MODE_FWM)[*3] |-> sda_oe_n)
    else $error("slave answered in master mode");
  open_drain_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("pin driven high");
  // Overflow: echoed, sticky, byte lost
  ovf_echo_a: assert property (serial_control_rd[7:6] == {1'b0, receive_overflow_bit})
    else $error("overflow echo wrong");
  ovf_sticky_a: assert property (receive_overflow_bit && !ovf_clr |=> receive_overflow_bit)
    else $error("overflow cleared by itself");
  ovf_keeps_a: assert property ($rose(receive_overflow_bit) |-> $stable(serial_buffer_reg))
    else $error("buffer replaced on overflow");
  // Completion flag follows every accepted byte
  done_sticky_a: assert property (transfer_done_flag && !done_clr |=> transfer_done_flag)
    else $error("done flag cleared by itself");
  buf_done_a: assert property ($changed(serial_buffer_reg) |-> transfer_done_flag && serial_status_reg[`ISSP_ST_BF])
    else $error("buffer loaded without done and full");
  off_hold_a: assert property ((!ctrl_in[`ISSP_EN_BIT])[*3] |-> $stable(serial_buffer_reg))
    else $error("buffer loaded while disabled");
  status_form_a: assert property (serial_status_reg[7:6] == 2'b00 && !(serial_status_reg[3] && serial_status_reg[4]))
    else $error("status word malformed");
endmodule

bind issp_core issp_sva u_sva (
  .mclk(mclk), .sys_rst(sys_rst), .scl_o(scl_o), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
  .ctrl_in(ctrl_in), .port_c_direction_bits(port_c_direction_bits),
  .ovf_clr(ovf_clr), .done_clr(done_clr), .serial_control_rd(serial_control_rd),
  .serial_status_reg(serial_status_reg), .transfer_done_flag(transfer_done_flag),
  .receive_overflow_bit(receive_overflow_bit), .serial_buffer_reg(serial_buffer_reg)
);
